/* File: common/vpe_regs.vh */
`ifndef VPE_REGS_VH
`define VPE_REGS_VH
// apb register map (byte addresses)
`define VPE_ADDR_CTRL 12'h000
`define VPE_ADDR_RESET_PCT 12'h004
`define VPE_ADDR_STATUS 12'h008
`define VPE_ADDR_UV_PICKUP 12'h010
`define VPE_ADDR_OV_PICKUP 12'h020
`define VPE_ADDR_GN_PICKUP 12'h030
`define VPE_ADDR_UV_DELAY 12'h040
`define VPE_ADDR_OV_DELAY 12'h050
`define VPE_ADDR_GN_DELAY 12'h060
// ctrl fields
`define VPE_CTRL_UV_EN 0
`define VPE_CTRL_OV_EN 3
`define VPE_CTRL_GN_EN 6
`define VPE_CTRL_UV_AND 8
`define VPE_CTRL_OV_AND 11
// reset percentage fields
`define VPE_PCT_UV_LSB 0
`define VPE_PCT_OV_LSB 8
`define VPE_PCT_GN_LSB 16
// reset values and percentage clamp limits
`define VPE_UV_PCT_RST 8'h69
`define VPE_OV_PCT_RST 8'h5f
`define VPE_GN_PCT_RST 8'h5f
`define VPE_UV_PCT_MIN 8'h65
`define VPE_UV_PCT_MAX 8'h96
`define VPE_OV_PCT_MIN 8'h32
`define VPE_OV_PCT_MAX 8'h63
`define VPE_UV_PICK_RST 16'h0fa0
`define VPE_OV_PICK_RST 16'h1b58
`define VPE_GN_PICK_RST 16'h03e8
// timing: tick period 10 ms at 200 MHz clock
`define VPE_CLK_MHZ 200
`define VPE_TICK_US 10000
`define VPE_TICK_CYCLES (`VPE_TICK_US * `VPE_CLK_MHZ)
`endif

/* File: rtl/vpe_detector.v */
`timescale 1ns/1ps
// level detector with hysteresis
module vpe_detector #(
   parameter W = 16
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_en,
   input wire i_over,
   input wire [W-1:0] i_value,
   input wire [W-1:0] i_pickup,
   input wire [7:0] i_pct,
   output reg o_picked
);
   wire [W+7:0] val_x100;
   wire [W+7:0] drop_lvl;
   wire [W+7:0] pick_x100;
   assign val_x100 = {8'h00, i_value} * {{W{1'b0}}, 8'h64};
   assign pick_x100 = {8'h00, i_pickup} * {{W{1'b0}}, 8'h64};
   assign drop_lvl = {8'h00, i_pickup} * {{W{1'b0}}, i_pct};
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_picked <= 1'b0;
      else if (!i_en)
         o_picked <= 1'b0;
      else if (i_over)
      begin
         if (val_x100 > pick_x100)
            o_picked <= 1'b1;
         else if (val_x100 < drop_lvl)
            o_picked <= 1'b0;
      end
      else
      begin
         if (val_x100 <= pick_x100)
            o_picked <= 1'b1;
         else if (val_x100 > drop_lvl)
            o_picked <= 1'b0;
      end
   end
endmodule

/* File: rtl/vpe_timer.v */
`timescale 1ns/1ps
// fixed-time integrator with block-trip latch
module vpe_timer #(
   parameter DW = 16
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_en,
   input wire i_tick,
   input wire i_pick,
   input wire i_block,
   input wire [DW-1:0] i_delay,
   output reg o_trip
);
   reg [DW-1:0] count;
   reg done;
   reg blocked;
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         count <= {DW{1'b0}};
         done <= 1'b0;
         blocked <= 1'b0;
         o_trip <= 1'b0;
      end
      else if (!i_en || !i_pick)
      begin
         count <= {DW{1'b0}};
         done <= 1'b0;
         blocked <= 1'b0;
         o_trip <= 1'b0;
      end
      else
      begin
         if (i_tick && !done)
         begin
            if (count >= i_delay)
               done <= 1'b1;
            else
               count <= count + {{(DW-1){1'b0}}, 1'b1};
         end
         if (i_block)
            blocked <= 1'b1;
         o_trip <= done && !blocked && !i_block;
      end
   end
endmodule

/* File: rtl/vpe_top.v */
`timescale 1ns/1ps
`include "vpe_regs.vh"
module vpe_top #(
   parameter VW = 16,
   parameter DW = 16,
   parameter TICK_CYCLES = `VPE_TICK_CYCLES
) (
   // clock and reset
   input wire I_CLK,
   input wire I_RESETN,
   // apb slave
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [11:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   output reg [31:0] O_PRDATA,
   output reg O_PREADY,
   output reg O_PSLVERR,
   // rms magnitudes per phase and of phasor sum
   input wire [VW-1:0] I_VA_RMS,
   input wire [VW-1:0] I_VB_RMS,
   input wire [VW-1:0] I_VC_RMS,
   input wire [VW-1:0] I_VN_RMS,
   // blocking inputs
   input wire I_ANY_POLE_OPEN,
   input wire I_FUSE_FAILURE_BLOCK,
   input wire [2:0] I_UV_BLOCK,
   input wire [2:0] I_OV_BLOCK,
   input wire [1:0] I_GN_BLOCK,
   // element outputs
   output reg [2:0] O_UV_PICKUP,
   output reg [2:0] O_UV_TRIP,
   output reg [2:0] O_OV_PICKUP,
   output reg [2:0] O_OV_TRIP,
   output reg [1:0] O_GN_PICKUP,
   output reg [1:0] O_GN_TRIP
);
   // ==========================================
   // reset synchroniser
   reg rst_meta;
   reg rst_n;
   always @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================
   // settings registers
   reg [15:0] ctrl;
   reg [7:0] uv_pct;
   reg [7:0] ov_pct;
   reg [7:0] gn_pct;
   reg [VW-1:0] uv_pick [0:2];
   reg [VW-1:0] ov_pick [0:2];
   reg [VW-1:0] gn_pick [0:1];
   reg [DW-1:0] uv_dly [0:2];
   reg [DW-1:0] ov_dly [0:2];
   reg [DW-1:0] gn_dly [0:1];

   function [7:0] clamp_pct;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         clamp_pct = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   function [31:0] widen;
      input [VW-1:0] v;
      begin
         widen = {{(32-VW){1'b0}}, v};
      end
   endfunction

   wire wr_en;
   wire rd_en;
   wire [3:0] idx;
   wire [11:0] base;
   assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
   assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;
   assign idx = {2'b00, I_PADDR[3:2]};
   assign base = {I_PADDR[11:4], 4'h0};
   wire arr3_ok;
   wire arr2_ok;
   assign arr3_ok = (idx < 4'h3) && (I_PADDR[1:0] == 2'b00);
   assign arr2_ok = (idx < 4'h2) && (I_PADDR[1:0] == 2'b00);

   reg hit;
   reg [31:0] rdata;
   wire [31:0] status_word;
   assign status_word = {16'h0000, O_GN_TRIP, O_OV_TRIP, O_UV_TRIP,
                         O_GN_PICKUP, O_OV_PICKUP, O_UV_PICKUP};

   always @*
   begin
      hit = 1'b1;
      rdata = 32'h00000000;
      if (I_PADDR == `VPE_ADDR_CTRL)
         rdata = {16'h0000, ctrl};
      else if (I_PADDR == `VPE_ADDR_RESET_PCT)
         rdata = {8'h00, gn_pct, ov_pct, uv_pct};
      else if (I_PADDR == `VPE_ADDR_STATUS)
         rdata = status_word;
      else if (base == `VPE_ADDR_UV_PICKUP && arr3_ok)
         rdata = widen(uv_pick[idx[1:0]]);
      else if (base == `VPE_ADDR_OV_PICKUP && arr3_ok)
         rdata = widen(ov_pick[idx[1:0]]);
      else if (base == `VPE_ADDR_GN_PICKUP && arr2_ok)
         rdata = widen(gn_pick[idx[0]]);
      else if (base == `VPE_ADDR_UV_DELAY && arr3_ok)
         rdata = {{(32-DW){1'b0}}, uv_dly[idx[1:0]]};
      else if (base == `VPE_ADDR_OV_DELAY && arr3_ok)
         rdata = {{(32-DW){1'b0}}, ov_dly[idx[1:0]]};
      else if (base == `VPE_ADDR_GN_DELAY && arr2_ok)
         rdata = {{(32-DW){1'b0}}, gn_dly[idx[0]]};
      else
         hit = 1'b0;
   end

   integer k;
   always @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= 16'h0000;
         uv_pct <= `VPE_UV_PCT_RST;
         ov_pct <= `VPE_OV_PCT_RST;
         gn_pct <= `VPE_GN_PCT_RST;
         for (k = 0; k < 3; k = k + 1)
         begin
            uv_pick[k] <= `VPE_UV_PICK_RST;
            ov_pick[k] <= `VPE_OV_PICK_RST;
            uv_dly[k] <= {DW{1'b0}};
            ov_dly[k] <= {DW{1'b0}};
         end
         for (k = 0; k < 2; k = k + 1)
         begin
            gn_pick[k] <= `VPE_GN_PICK_RST;
            gn_dly[k] <= {DW{1'b0}};
         end
         O_PRDATA <= 32'h00000000;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
         O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !hit;
         O_PRDATA <= (rd_en && !O_PREADY) ? rdata : 32'h00000000;
         if (wr_en && O_PREADY && hit)
         begin
            if (I_PADDR == `VPE_ADDR_CTRL)
               ctrl <= I_PWDATA[15:0];
            else if (I_PADDR == `VPE_ADDR_RESET_PCT)
            begin
               uv_pct <= clamp_pct(I_PWDATA[7:0], `VPE_UV_PCT_MIN, `VPE_UV_PCT_MAX);
               ov_pct <= clamp_pct(I_PWDATA[15:8], `VPE_OV_PCT_MIN, `VPE_OV_PCT_MAX);
               gn_pct <= clamp_pct(I_PWDATA[23:16], `VPE_OV_PCT_MIN, `VPE_OV_PCT_MAX);
            end
            else if (base == `VPE_ADDR_UV_PICKUP)
               uv_pick[idx[1:0]] <= I_PWDATA[VW-1:0];
            else if (base == `VPE_ADDR_OV_PICKUP)
               ov_pick[idx[1:0]] <= I_PWDATA[VW-1:0];
            else if (base == `VPE_ADDR_GN_PICKUP)
               gn_pick[idx[0]] <= I_PWDATA[VW-1:0];
            else if (base == `VPE_ADDR_UV_DELAY)
               uv_dly[idx[1:0]] <= I_PWDATA[DW-1:0];
            else if (base == `VPE_ADDR_OV_DELAY)
               ov_dly[idx[1:0]] <= I_PWDATA[DW-1:0];
            else if (base == `VPE_ADDR_GN_DELAY)
               gn_dly[idx[0]] <= I_PWDATA[DW-1:0];
         end
      end
   end

   // ==========================================
   // tick divider
   reg [31:0] div_cnt;
   reg tick;
   always @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt <= 32'h00000000;
         tick <= 1'b0;
      end
      else if (div_cnt >= TICK_CYCLES - 1)
      begin
         div_cnt <= 32'h00000000;
         tick <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 32'h00000001;
         tick <= 1'b0;
      end
   end

   // ==========================================
   // elements
   wire sys_block;
   assign sys_block = I_ANY_POLE_OPEN || I_FUSE_FAILURE_BLOCK;
   wire [VW-1:0] phase_v [0:2];
   assign phase_v[0] = I_VA_RMS;
   assign phase_v[1] = I_VB_RMS;
   assign phase_v[2] = I_VC_RMS;

   wire [2:0] uv_ph [0:2];
   wire [2:0] ov_ph [0:2];
   wire [2:0] uv_comb;
   wire [2:0] ov_comb;
   wire [2:0] uv_trip;
   wire [2:0] ov_trip;
   wire [1:0] gn_pk;
   wire [1:0] gn_trip;

   genvar e;
   genvar p;
   generate
      for (e = 0; e < 3; e = e + 1)
      begin : g_ph
         for (p = 0; p < 3; p = p + 1)
         begin : g_p
            vpe_detector #(.W(VW)) u_uv (
               .i_clk(I_CLK),
               .i_rst_n(rst_n),
               .i_en(ctrl[`VPE_CTRL_UV_EN + e]),
               .i_over(1'b0),
               .i_value(phase_v[p]),
               .i_pickup(uv_pick[e]),
               .i_pct(uv_pct),
               .o_picked(uv_ph[e][p])
            );
            vpe_detector #(.W(VW)) u_ov (
               .i_clk(I_CLK),
               .i_rst_n(rst_n),
               .i_en(ctrl[`VPE_CTRL_OV_EN + e]),
               .i_over(1'b1),
               .i_value(phase_v[p]),
               .i_pickup(ov_pick[e]),
               .i_pct(ov_pct),
               .o_picked(ov_ph[e][p])
            );
         end
         assign uv_comb[e] = ctrl[`VPE_CTRL_UV_AND + e] ? (&uv_ph[e]) : (|uv_ph[e]);
         assign ov_comb[e] = ctrl[`VPE_CTRL_OV_AND + e] ? (&ov_ph[e]) : (|ov_ph[e]);
         vpe_timer #(.DW(DW)) u_uvt (
            .i_clk(I_CLK),
            .i_rst_n(rst_n),
            .i_en(ctrl[`VPE_CTRL_UV_EN + e] && !sys_block),
            .i_tick(tick),
            .i_pick(uv_comb[e]),
            .i_block(I_UV_BLOCK[e]),
            .i_delay(uv_dly[e]),
            .o_trip(uv_trip[e])
         );
         vpe_timer #(.DW(DW)) u_ovt (
            .i_clk(I_CLK),
            .i_rst_n(rst_n),
            .i_en(ctrl[`VPE_CTRL_OV_EN + e]),
            .i_tick(tick),
            .i_pick(ov_comb[e]),
            .i_block(I_OV_BLOCK[e]),
            .i_delay(ov_dly[e]),
            .o_trip(ov_trip[e])
         );
      end
      for (e = 0; e < 2; e = e + 1)
      begin : g_gn
         vpe_detector #(.W(VW)) u_gn (
            .i_clk(I_CLK),
            .i_rst_n(rst_n),
            .i_en(ctrl[`VPE_CTRL_GN_EN + e]),
            .i_over(1'b1),
            .i_value(I_VN_RMS),
            .i_pickup(gn_pick[e]),
            .i_pct(gn_pct),
            .o_picked(gn_pk[e])
         );
         vpe_timer #(.DW(DW)) u_gnt (
            .i_clk(I_CLK),
            .i_rst_n(rst_n),
            .i_en(ctrl[`VPE_CTRL_GN_EN + e] && !sys_block),
            .i_tick(tick),
            .i_pick(gn_pk[e]),
            .i_block(I_GN_BLOCK[e]),
            .i_delay(gn_dly[e]),
            .o_trip(gn_trip[e])
         );
      end
   endgenerate

   // ==========================================
   // registered outputs
   always @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         O_UV_PICKUP <= 3'h0;
         O_UV_TRIP <= 3'h0;
         O_OV_PICKUP <= 3'h0;
         O_OV_TRIP <= 3'h0;
         O_GN_PICKUP <= 2'h0;
         O_GN_TRIP <= 2'h0;
      end
      else
      begin
         O_UV_PICKUP <= uv_comb & {3{!sys_block}};
         O_UV_TRIP <= uv_trip;
         O_OV_PICKUP <= ov_comb;
         O_OV_TRIP <= ov_trip;
         O_GN_PICKUP <= gn_pk & {2{!sys_block}};
         O_GN_TRIP <= gn_trip;
      end
   end
endmodule

/* File: verif/vpe_front_model.sv */
`timescale 1ns/1ps
// ==========
// measurement front end and neighbour flags, one update per clock
module vpe_front_model (
   // clock
   input logic i_clk,
   // requested values
   input logic [15:0] i_va, i_vb, i_vc, i_vn,
   input logic i_pole, i_fuse,
   // values seen by the block
   output logic [15:0] o_va = 16'h0, o_vb = 16'h0, o_vc = 16'h0, o_vn = 16'h0,
   output logic o_pole = 1'b0, o_fuse = 1'b0
);
   always @(posedge i_clk)
   begin
      {o_va, o_vb, o_vc, o_vn, o_pole, o_fuse} <= {i_va, i_vb, i_vc, i_vn, i_pole, i_fuse};
   end
endmodule

/* File: verif/vpe_top_monitor.sv */
`timescale 1ns/1ps
// ==========
// element output checks
module vpe_top_monitor (
   // clock and reset
   input logic I_CLK,
   input logic I_RESETN,
   // blocking inputs
   input logic I_ANY_POLE_OPEN,
   input logic I_FUSE_FAILURE_BLOCK,
   input logic [2:0] I_UV_BLOCK,
   input logic [2:0] I_OV_BLOCK,
   input logic [1:0] I_GN_BLOCK,
   // element outputs
   input logic [2:0] O_UV_PICKUP,
   input logic [2:0] O_UV_TRIP,
   input logic [2:0] O_OV_PICKUP,
   input logic [2:0] O_OV_TRIP,
   input logic [1:0] O_GN_PICKUP,
   input logic [1:0] O_GN_TRIP
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESETN);
   logic blk;
   assign blk = I_ANY_POLE_OPEN | I_FUSE_FAILURE_BLOCK;
   chk_uv_blocked: assert property (blk [*5] |-> (O_UV_PICKUP | O_UV_TRIP) == 3'h0)
      else $error("uv active while blocked");
   chk_gn_blocked: assert property (blk [*5] |-> (O_GN_PICKUP | O_GN_TRIP) == 2'h0)
      else $error("ground active while blocked");
   chk_uv_trip_block: assert property (
      (O_UV_TRIP & $past(I_UV_BLOCK) & $past(I_UV_BLOCK, 2) & $past(I_UV_BLOCK, 3)
      & $past(I_UV_BLOCK, 4)) == 3'h0) else $error("uv trip through block");
   chk_ov_trip_block: assert property (
      (O_OV_TRIP & $past(I_OV_BLOCK) & $past(I_OV_BLOCK, 2) & $past(I_OV_BLOCK, 3)
      & $past(I_OV_BLOCK, 4)) == 3'h0) else $error("ov trip through block");
   chk_gn_trip_block: assert property (
      (O_GN_TRIP & $past(I_GN_BLOCK) & $past(I_GN_BLOCK, 2) & $past(I_GN_BLOCK, 3)
      & $past(I_GN_BLOCK, 4)) == 2'h0) else $error("ground trip through block");
   chk_uv_trip_pick: assert property (
      (O_UV_TRIP & ~O_UV_PICKUP & ~$past(O_UV_PICKUP) & ~$past(O_UV_PICKUP, 2)
      & ~$past(O_UV_PICKUP, 3)) == 3'h0) else $error("uv trip without pickup");
   chk_ov_trip_pick: assert property (
      (O_OV_TRIP & ~O_OV_PICKUP & ~$past(O_OV_PICKUP) & ~$past(O_OV_PICKUP, 2)
      & ~$past(O_OV_PICKUP, 3)) == 3'h0) else $error("ov trip without pickup");
   chk_gn_trip_pick: assert property (
      (O_GN_TRIP & ~O_GN_PICKUP & ~$past(O_GN_PICKUP) & ~$past(O_GN_PICKUP, 2)
      & ~$past(O_GN_PICKUP, 3)) == 2'h0) else $error("ground trip without pickup");
endmodule

bind vpe_top vpe_top_monitor chk_u (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
   .I_ANY_POLE_OPEN(I_ANY_POLE_OPEN), .I_FUSE_FAILURE_BLOCK(I_FUSE_FAILURE_BLOCK),
   .I_UV_BLOCK(I_UV_BLOCK), .I_OV_BLOCK(I_OV_BLOCK), .I_GN_BLOCK(I_GN_BLOCK),
   .O_UV_PICKUP(O_UV_PICKUP), .O_UV_TRIP(O_UV_TRIP), .O_OV_PICKUP(O_OV_PICKUP),
   .O_OV_TRIP(O_OV_TRIP), .O_GN_PICKUP(O_GN_PICKUP), .O_GN_TRIP(O_GN_TRIP));

/* File: verif/voltage_protection_elements_test.sv */
`timescale 1ns/1ps
`include "vpe_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: %h not %h", $time, g, e); end end
module voltage_protection_elements_test;
   localparam int L = 30;
   localparam int NM = 4500;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er, pready, pslverr;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rdata, rd, wv, xp;
   logic [15:0] tva = 16'h0, tvb = 16'h0, tvc = 16'h0, tvn = 16'h0, va, vb, vc, vn;
   logic tpole = 1'b0, tfuse = 1'b0, pole, fuse;
   logic [2:0] ub = 3'h0, ob = 3'h0, up, ut, op, ot;
   logic [1:0] gb = 2'h0, gp, gt;
   logic [11:0] ra [6] = '{`VPE_ADDR_CTRL, `VPE_ADDR_RESET_PCT, `VPE_ADDR_UV_PICKUP + 12'h8,
      `VPE_ADDR_OV_PICKUP, `VPE_ADDR_GN_PICKUP + 12'h4, `VPE_ADDR_UV_DELAY};
   logic [31:0] rv [6] = '{32'h0, 32'h005f5f69, 32'h0fa0, 32'h1b58, 32'h03e8, 32'h0};
   int fail_count = 0, tests_run = 0, pu, po, pg, thr;

   vpe_front_model fe_u (.i_clk(clk), .i_va(tva), .i_vb(tvb), .i_vc(tvc), .i_vn(tvn),
      .i_pole(tpole), .i_fuse(tfuse), .o_va(va), .o_vb(vb), .o_vc(vc), .o_vn(vn),
      .o_pole(pole), .o_fuse(fuse));
   vpe_top #(.TICK_CYCLES(4)) dut_u (.I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(rdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_VA_RMS(va),
      .I_VB_RMS(vb), .I_VC_RMS(vc), .I_VN_RMS(vn), .I_ANY_POLE_OPEN(pole),
      .I_FUSE_FAILURE_BLOCK(fuse), .I_UV_BLOCK(ub), .I_OV_BLOCK(ob), .I_GN_BLOCK(gb),
      .O_UV_PICKUP(up), .O_UV_TRIP(ut), .O_OV_PICKUP(op), .O_OV_TRIP(ot),
      .O_GN_PICKUP(gp), .O_GN_TRIP(gt));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   // ==========
   // helpers
   function automatic logic [15:0] ev(input logic [5:0] u, o, input logic [3:0] g);
      ev = {u, o, g};
   endfunction

   function automatic logic [7:0] clamp(input logic [7:0] v, lo, hi);
      clamp = v < lo ? lo : (v > hi ? hi : v);
   endfunction

   task complete_run();
      begin
         $display("comparisons %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge clk);
         psel <= 1'b1;
         pwr <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         pen <= 1'b1;
         @(posedge clk);
         n = 1;
         while (pready !== 1'b1 && n < 20)
         begin
            @(posedge clk);
            n++;
         end
         if (pready !== 1'b1)
         begin
            fail_count++;
            complete_run();
         end
         rd = rdata;
         er = pslverr;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask

   task automatic step(input int a, b, c, n, input logic [9:0] bk, input int cy,
         input logic [15:0] ex);
      begin
         @(posedge clk);
         tva <= a[15:0];
         tvb <= b[15:0];
         tvc <= c[15:0];
         tvn <= n[15:0];
         {tpole, tfuse, ub, ob, gb} <= bk;
         repeat (cy) @(posedge clk);
         @(negedge clk);
         `CHK({up, ut, op, ot, gp, gt}, ex)
      end
   endtask

   // ==========
   // main sequence
   initial
   begin
      void'($urandom(52642));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, ra[i], 32'h0);
         `CHK({er, rd}, {1'b0, rv[i]})
      end
      apb(1'b0, 12'h00c, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      for (int i = 0; i < 5; i++)
      begin
         wv = i == 0 ? 32'h00316464 : $urandom;
         apb(1'b1, `VPE_ADDR_RESET_PCT, wv);
         apb(1'b0, `VPE_ADDR_RESET_PCT, 32'h0);
         xp = {8'h0, clamp(wv[23:16], `VPE_OV_PCT_MIN, `VPE_OV_PCT_MAX),
            clamp(wv[15:8], `VPE_OV_PCT_MIN, `VPE_OV_PCT_MAX),
            clamp(wv[7:0], `VPE_UV_PCT_MIN, `VPE_UV_PCT_MAX)};
         `CHK(rd, xp)
      end
      apb(1'b1, `VPE_ADDR_RESET_PCT, 32'h005f5f69);
      pu = 2000 + $urandom % 1000;
      po = 6000 + $urandom % 1000;
      pg = 500 + $urandom % 500;
      apb(1'b1, `VPE_ADDR_UV_PICKUP, 32'(pu));
      apb(1'b1, `VPE_ADDR_UV_PICKUP + 12'h4, 32'(pu));
      apb(1'b1, `VPE_ADDR_OV_PICKUP, 32'(po));
      apb(1'b1, `VPE_ADDR_OV_PICKUP + 12'h4, 32'(po));
      apb(1'b1, `VPE_ADDR_GN_PICKUP, 32'(pg));
      apb(1'b1, `VPE_ADDR_UV_DELAY + 12'h4, 32'h2);
      apb(1'b1, `VPE_ADDR_CTRL, 32'h125b);
      step(NM, NM, NM, 0, 10'h0, L, 16'h0);
      step(pu, NM, NM, 0, 10'h0, L, ev(6'h09, 6'h0, 4'h0));
      step(pu, pu, pu, 0, 10'h0, 6, ev(6'h19, 6'h0, 4'h0));
      step(pu, pu, pu, 0, 10'h0, L, ev(6'h1b, 6'h0, 4'h0));
      thr = pu * 105 / 100;
      step(thr, thr, thr, 0, 10'h0, L, ev(6'h1b, 6'h0, 4'h0));
      step(thr, thr + 1, thr + 1, 0, 10'h0, L, ev(6'h09, 6'h0, 4'h0));
      step(pu, pu, pu, 0, 10'h0, 6, ev(6'h19, 6'h0, 4'h0));
      step(pu, pu, pu, 0, 10'h040, L, ev(6'h19, 6'h0, 4'h0));
      step(NM, NM, NM, 0, 10'h0, L, 16'h0);
      step(po, NM, NM, 0, 10'h0, L, 16'h0);
      step(po + 1, NM, NM, 0, 10'h0, L, ev(6'h0, 6'h09, 4'h0));
      step(po + 1, po + 1, po + 1, 0, 10'h0, L, ev(6'h0, 6'h1b, 4'h0));
      apb(1'b0, `VPE_ADDR_STATUS, 32'h0);
      `CHK(rd, 32'h00001818)
      thr = (po * 95 + 99) / 100;
      step(thr, thr, thr, 0, 10'h0, L, ev(6'h0, 6'h1b, 4'h0));
      step(thr - 1, thr, thr, 0, 10'h0, L, ev(6'h0, 6'h09, 4'h0));
      step(thr - 1, thr, thr, 0, 10'h004, L, ev(6'h0, 6'h08, 4'h0));
      step(NM, NM, NM, pg, 10'h0, L, 16'h0);
      step(NM, NM, NM, pg + 1, 10'h001, L, ev(6'h0, 6'h0, 4'h4));
      step(NM, NM, NM, 0, 10'h0, L, 16'h0);
      step(NM, NM, NM, pg + 1, 10'h0, L, ev(6'h0, 6'h0, 4'h5));
      step(NM, NM, NM, pg + 1, 10'h001, L, ev(6'h0, 6'h0, 4'h4));
      for (int k = 0; k < 2; k++)
      begin
         step(NM, NM, NM, 0, 10'h0, L, 16'h0);
         step(pu, NM, NM, pg + 1, 10'h0, L, ev(6'h09, 6'h0, 4'h5));
         step(pu, NM, NM, pg + 1, k ? 10'h100 : 10'h200, L, 16'h0);
      end
      complete_run();
   end
endmodule
